/* igsc_asserts.sv */
// Purpose: port-level checks of the acquisition controller.
// Assumes: clkEn held high, one clock domain.
// Notes:   bound onto the controller from the bench.
`timescale 1ns/100ps
module igsc_asserts
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic cathodeBias,
  input wire logic alarmSound,
  input wire logic gateStartPulse,
  input wire logic gateStopPulse,
  input wire logic auxPulse,
  input wire logic exposureActive,
  input wire logic readoutActive,
  input wire logic cleaning,
  input wire logic genBusy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_ready;
    pready == (psel && penable);
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready outside access phase");

  // one cycle of grace: bias is a register behind the alarm level
  property p_alarm;
    alarmSound && $past(alarmSound) |-> !cathodeBias;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("bias on during alarm");

  property p_start;
    gateStartPulse |=> !gateStartPulse;
  endproperty
  a_start: assert property (p_start)
    else $error("gate start longer than a cycle");

  property p_ens;
    gateStopPulse |=> auxPulse ##1 !auxPulse;
  endproperty
  a_ens: assert property (p_ens)
    else $error("aux pulse not after gate stop");

  property p_rdbusy;
    $rose(readoutActive) |-> !genBusy;
  endproperty
  a_rdbusy: assert property (p_rdbusy)
    else $error("readout began with generator busy");

  property p_nopulse;
    gateStartPulse |-> !readoutActive;
  endproperty
  a_nopulse: assert property (p_nopulse)
    else $error("gate pulse during readout");

  property p_clean;
    exposureActive |-> !cleaning;
  endproperty
  a_clean: assert property (p_clean)
    else $error("clean running during exposure");

  property p_rdbias;
    readoutActive && $past(readoutActive) |-> !cathodeBias;
  endproperty
  a_rdbias: assert property (p_rdbias)
    else $error("bias on during readout");
endmodule

/* igsc_controller.sv */
// Purpose: acquisition sequencing, pulse generator and cathode bias
//          control of an intensified camera, with APB registers.
// Assumes: one 20 MHz clock; sync, trigger and overload pins asynchronous.
// Notes:   zero-wait APB slave; unmapped addresses answer pslverr.
`timescale 1ns/100ps
module igsc_controller
  import igsc_pkg::*;
#(
  parameter int unsigned COMP_LEN    = COMP_CYCLES,
  parameter int unsigned CLEAN_LEN   = CLEAN_CYCLES,
  parameter int unsigned READOUT_LEN = READOUT_CYCLES,
  parameter bit          GEN_FITTED  = 1'b1
)
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              clkEn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire logic              extSyncPin,
  input  wire logic              genTrigPin,
  input  wire logic              overloadPin,
  output      logic              cathodeBias,
  output      logic              alarmSound,
  output      logic              gateStartPulse,
  output      logic              gateStopPulse,
  output      logic              auxPulse,
  output      logic              exposureActive,
  output      logic              readoutActive,
  output      logic              cleaning,
  output      logic              genBusy,
  output      logic              irq
);

  typedef struct packed {
    igsc_ctrl_type  ctrl;
    logic [31:0]    exposure;
    logic [15:0]    gateWidth;
    logic [INT_W-1:0] intStatus;
    logic [INT_W-1:0] intMask;
    logic           armed;
    igsc_state_type state;
    logic [31:0]    cnt;
    logic [31:0]    cleanCnt;
    igsc_gen_type   gen;
    logic [15:0]    genCnt;
    logic           gateOn;
    logic           bias;
    logic           startPulse;
    logic           stopPulse;
    logic           auxOut;
    logic [31:0]    rdata;
  } igsc_regs_type;

  localparam igsc_regs_type REGS_RESET = '{
    ctrl: CTRL_RESET, exposure: EXPOSURE_RESET,
    gateWidth: GATE_WIDTH_RESET, intStatus: '0, intMask: '0,
    armed: 1'b0, state: ST_IDLE, cnt: '0, cleanCnt: '0, gen: GEN_IDLE,
    genCnt: '0, gateOn: 1'b0, bias: 1'b0, startPulse: 1'b0,
    stopPulse: 1'b0, auxOut: 1'b0, rdata: '0};

  igsc_regs_type r;
  igsc_regs_type next_r;

  logic [PIN_COUNT-1:0] pinLevel;
  logic [PIN_COUNT-1:0] pinRise;
  logic [PIN_COUNT-1:0] pinFall;

  igsc_pin_sync #(
    .WIDTH (PIN_COUNT)
  ) pinSync (
    .clk   (clk),
    .reset (reset),
    .clkEn (clkEn),
    .pinIn ({overloadPin, genTrigPin, extSyncPin}),
    .level (pinLevel),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  // effective settings and decoded bus signals
  logic             gateMode;
  igsc_timing_type  timingEff;
  igsc_shutter_type shutterEff;
  logic             contEff;
  logic             earlyEff;
  logic [31:0]      exposureEff;
  logic             syncEdge;
  logic             genEdge;
  logic             alarm;
  logic             hit;
  logic             wrAccess;
  logic             trigger;
  logic             genFire;
  logic             ensembleDone;
  logic             cleanRun;
  logic [INT_W-1:0] events;
  logic [31:0]      readMux;
  logic [32:0]      cntNext;
  igsc_ctrl_type    wrCtrl;

  always_comb
  begin
    gateMode = (r.ctrl.mode == MODE_GATE);
    // gate mode overrides timing, shutter, cleans and exposure
    timingEff = gateMode ? TIMING_INTERNAL : r.ctrl.timing;
    shutterEff = gateMode ? SHUT_NONE : r.ctrl.shutter;
    contEff = gateMode ? 1'b0 : r.ctrl.contCleans;
    earlyEff = gateMode ? 1'b1 : r.ctrl.earlyBiasOn;
    exposureEff = gateMode ? 32'h0 : r.exposure;
    syncEdge = r.ctrl.syncRising ? pinRise[PIN_SYNC]
                                 : pinFall[PIN_SYNC];
    genEdge = r.ctrl.genTrigRising ? pinRise[PIN_GEN_TRIG]
                                   : pinFall[PIN_GEN_TRIG];
    alarm = pinLevel[PIN_OVERLOAD];
    wrCtrl = igsc_ctrl_type'(pwdata[CTRL_W-1:0]);
    hit = 1'b1;
    unique case (paddr)
      OFS_CTRL:       readMux = {{(32-CTRL_W){1'b0}}, r.ctrl};
      OFS_EXPOSURE:   readMux = r.exposure;
      OFS_GATE_WIDTH: readMux = {16'h0000, r.gateWidth};
      OFS_STATUS:     readMux = {20'h00000, r.gen, alarm, r.gateOn,
                                 r.bias, r.armed, gateMode,
                                 timingEff, r.state};
      OFS_INT_STATUS: readMux = {{(32-INT_W){1'b0}}, r.intStatus};
      OFS_INT_MASK:   readMux = {{(32-INT_W){1'b0}}, r.intMask};
      OFS_COMMAND:    readMux = 32'h0000_0000;
      default:
      begin
        readMux = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    wrAccess = psel & penable & pwrite & hit;
  end

  always_comb
  begin
    next_r = r;
    events = '0;
    next_r.startPulse = 1'b0;
    next_r.stopPulse = 1'b0;
    next_r.auxOut = 1'b0;
    cntNext = {1'b0, r.cnt} + 33'h1;

    // read data is captured in the setup phase so prdata is a flop
    if (psel & ~penable)
      next_r.rdata = readMux;

    // pulse generator
    genFire = 1'b0;
    ensembleDone = 1'b0;
    unique case (r.gen)
      GEN_IDLE:
      begin
        // never fires outside the wait state, so never pulses during readout
        if (GEN_FITTED && timingEff == TIMING_INTERNAL && r.armed &&
            r.state == ST_WAIT && (!r.ctrl.genTrigWait || genEdge))
        begin
          genFire = 1'b1;
          next_r.startPulse = genFire;
          next_r.gateOn = 1'b1;
          next_r.genCnt = 16'h0000;
          next_r.gen = GEN_ON;
        end
      end
      GEN_ON:
      begin
        next_r.genCnt = r.genCnt + 16'h0001;
        if (r.genCnt + 16'h0001 >= r.gateWidth)
        begin
          next_r.stopPulse = 1'b1;
          next_r.gateOn = 1'b0;
          next_r.gen = GEN_AUX;
        end
      end
      GEN_AUX:
      begin
        next_r.auxOut = 1'b1;
        ensembleDone = 1'b1;
        next_r.gen = GEN_IDLE;
      end
      default:
      begin
        next_r.gen = GEN_IDLE;
        next_r.gateOn = 1'b0;
      end
    endcase
    events[INT_ENSEMBLE] = ensembleDone;

    // clean cycles run while idle, during continuous cleans, and
    // otherwise only until the one in progress completes
    cleanRun = (r.state == ST_IDLE) || (r.cleanCnt != 32'h0) ||
               (r.state == ST_WAIT && contEff);
    if (cleanRun)
      next_r.cleanCnt = (r.cleanCnt + 32'h1 >= 32'(CLEAN_LEN)) ? 32'h0
                        : r.cleanCnt + 32'h1;

    unique case (timingEff)
      TIMING_EXT_SYNC: trigger = syncEdge;
      TIMING_INTERNAL: trigger = ensembleDone;
      default:         trigger = 1'b1;
    endcase

    unique case (r.state)
      ST_IDLE:
      begin
        if (r.armed)
          next_r.state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (!r.armed)
          next_r.state = ST_IDLE;
        else if (trigger)
        begin
          events[INT_TRIGGER] = 1'b1;
          next_r.state = ST_FINISH;
        end
      end
      ST_FINISH:
      begin
        if (r.cleanCnt == 32'h0)
        begin
          next_r.cnt = 32'h0;
          next_r.state = ST_EXPOSE;
        end
      end
      ST_EXPOSE:
      begin
        next_r.cnt = cntNext[31:0];
        if (cntNext >= {1'b0, exposureEff})
        begin
          if (shutterEff != SHUT_NONE)
          begin
            next_r.cnt = 32'h0;
            next_r.state = ST_COMP;
          end
          else if (r.gen == GEN_IDLE)
          begin
            next_r.cnt = 32'h0;
            next_r.state = ST_READ;
          end
        end
      end
      ST_COMP:
      begin
        next_r.cnt = cntNext[31:0];
        if (cntNext >= {1'b0, 32'(COMP_LEN)} && r.gen == GEN_IDLE)
        begin
          next_r.cnt = 32'h0;
          next_r.state = ST_READ;
        end
      end
      ST_READ:
      begin
        next_r.cnt = cntNext[31:0];
        if (cntNext >= {1'b0, 32'(READOUT_LEN)})
        begin
          events[INT_FRAME] = 1'b1;
          next_r.cnt = 32'h0;
          next_r.state = r.armed ? ST_WAIT : ST_IDLE;
        end
      end
    endcase

    // cathode bias: safe mode and alarm override everything
    if (r.ctrl.mode == MODE_SAFE || alarm)
      next_r.bias = 1'b0;
    else if (gateMode)
      next_r.bias = next_r.gateOn;
    else
      next_r.bias = (next_r.state == ST_EXPOSE) ||
                    (earlyEff && r.armed && (next_r.state == ST_WAIT ||
                     next_r.state == ST_FINISH));
    events[INT_OVERLOAD] = pinRise[PIN_OVERLOAD];

    // register writes
    if (wrAccess)
    begin
      unique case (paddr)
        OFS_CTRL:
        begin
          if (gateMode || wrCtrl.mode == MODE_GATE)
          begin
            // locked fields keep their values while gate mode holds
            next_r.ctrl.mode = wrCtrl.mode;
            next_r.ctrl.genTrigWait = wrCtrl.genTrigWait;
            next_r.ctrl.genTrigRising = wrCtrl.genTrigRising;
            if (wrCtrl.timing != TIMING_INTERNAL)
              events[INT_REJECT] = 1'b1;
          end
          else
            next_r.ctrl = wrCtrl;
        end
        OFS_EXPOSURE:
        begin
          if (!gateMode)
            next_r.exposure = pwdata;
        end
        OFS_GATE_WIDTH: next_r.gateWidth = pwdata[15:0];
        OFS_INT_STATUS:
          next_r.intStatus = r.intStatus & ~pwdata[INT_W-1:0];
        OFS_INT_MASK:   next_r.intMask = pwdata[INT_W-1:0];
        OFS_COMMAND:
        begin
          if (pwdata[CMD_STOP_BIT])
            next_r.armed = 1'b0;
          else if (pwdata[CMD_START_BIT])
            next_r.armed = 1'b1;
        end
        default:
        begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_r.intStatus = next_r.intStatus | events;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      r <= REGS_RESET;
    else if (clkEn)
      r <= next_r;
  end

  assign prdata = r.rdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign cathodeBias = r.bias;
  assign alarmSound = pinLevel[PIN_OVERLOAD];
  assign gateStartPulse = r.startPulse;
  assign gateStopPulse = r.stopPulse;
  assign auxPulse = r.auxOut;
  assign exposureActive = (r.state == ST_EXPOSE);
  assign readoutActive = (r.state == ST_READ);
  assign cleaning = (r.state == ST_IDLE) || (r.cleanCnt != 32'h0);
  assign genBusy = (r.gen != GEN_IDLE);
  assign irq = |(r.intStatus & r.intMask);

endmodule

/* igsc_partner.sv */
// Purpose: stand-in for the TTL sync, trigger and overload sources.
// Assumes: levels change just after a rising clock edge.
// Notes:   lines hold their level; the controller treats them as async.
`timescale 1ns/100ps
module igsc_partner
(
  input  wire logic clk,
  output      logic extSyncPin,
  output      logic genTrigPin,
  output      logic overloadPin
);
  initial
  begin
    extSyncPin  = 1'h0;
    genTrigPin  = 1'h0;
    overloadPin = 1'h0;
  end

  // pin 0 sync, 1 generator trigger, other overload
  task drive(input int pin, input logic lvl);
    @(posedge clk);
    case (pin)
      0:       extSyncPin  <= lvl;
      1:       genTrigPin  <= lvl;
      default: overloadPin <= lvl;
    endcase
  endtask
endmodule

/* igsc_pin_sync.sv */
// Purpose: three-stage synchroniser with settled level and edge pulses.
// Assumes: inputs asynchronous to clk.
// Notes:   a level counts once stages two and three agree.
`timescale 1ns/100ps
module igsc_pin_sync
  import igsc_pkg::*;
#(
  parameter int unsigned WIDTH = 3
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] pinIn,
  output      logic [WIDTH-1:0] level,
  output      logic [WIDTH-1:0] rise,
  output      logic [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
  } igsc_sync_type;

  igsc_sync_type r;
  igsc_sync_type next_r;
  logic [WIDTH-1:0] agree;

  always_comb
  begin
    next_r = r;
    agree = ~(r.s2 ^ r.s3);
    next_r.s1 = pinIn;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.level = (r.s2 & agree) | (r.level & ~agree);
    next_r.rise = next_r.level & ~r.level;
    next_r.fall = ~next_r.level & r.level;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      r <= '0;
    else if (clkEn)
      r <= next_r;
  end

  assign level = r.level;
  assign rise = r.rise;
  assign fall = r.fall;

endmodule

/* igsc_pkg.sv */
// Purpose: constants, register map and types of the intensifier gate and
//          sync controller.
// Assumes: 20 MHz clock, APB register access, 32-bit data.
// Notes:   register offsets are byte addresses.
// Summary of operation
// - In external sync, exposure waits for both the start command and a sync edge of the chosen polarity.
// - After the qualifying trigger the clean cycle in progress finishes and acquisition starts at once.
// - A cycle is exposure, then shutter compensation unless the shutter type is none, then readout.
// - In internal sync with the pulse generator fitted, its ensemble is the trigger source.
// - The pulse generator may wait for an edge of the chosen polarity on its own trigger input.
// - In shutter mode the cathode bias is on for the whole exposure.
// - In gate mode the cathode bias is on only between the gate start and gate stop pulses.
// - In safe mode the cathode bias is always off.
// - While the light overload alarm sounds the cathode bias is off.
// - In gate mode only internal sync is used; other timing selections are overridden.
// - In gate mode one readout follows each completed pulse ensemble.
// - Readout cannot start while the generator is busy, and it never pulses during readout.
// - Gate mode forces exposure 0, no continuous cleans, open shutter and early bias, and locks them.
// - An ensemble is a gate start pulse, a gate stop pulse and an auxiliary pulse.
package igsc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_EXPOSURE   = 8'h04;
  localparam logic [7:0] OFS_GATE_WIDTH = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_MASK   = 8'h14;
  localparam logic [7:0] OFS_COMMAND    = 8'h18;

  localparam int unsigned CTRL_W = 11;
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_STOP_BIT  = 1;

  localparam int unsigned INT_W         = 5;
  localparam int unsigned INT_FRAME     = 0;
  localparam int unsigned INT_TRIGGER   = 1;
  localparam int unsigned INT_OVERLOAD  = 2;
  localparam int unsigned INT_ENSEMBLE  = 3;
  localparam int unsigned INT_REJECT    = 4;

  // pin synchroniser lanes
  localparam int unsigned PIN_SYNC     = 0;
  localparam int unsigned PIN_GEN_TRIG = 1;
  localparam int unsigned PIN_OVERLOAD = 2;
  localparam int unsigned PIN_COUNT    = 3;

  typedef enum logic [1:0] {
    MODE_SHUTTER = 2'h0,
    MODE_GATE    = 2'h1,
    MODE_SAFE    = 2'h2
  } igsc_mode_type;

  typedef enum logic [1:0] {
    TIMING_FREE_RUN = 2'h0,
    TIMING_EXT_SYNC = 2'h1,
    TIMING_INTERNAL = 2'h2
  } igsc_timing_type;

  typedef enum logic [1:0] {
    SHUT_NONE       = 2'h0,
    SHUT_ELECTRONIC = 2'h1,
    SHUT_MECHANICAL = 2'h2
  } igsc_shutter_type;

  typedef struct packed {
    logic             genTrigRising;
    logic             genTrigWait;
    logic             earlyBiasOn;
    logic             contCleans;
    igsc_shutter_type shutter;
    logic             syncRising;
    igsc_timing_type  timing;
    igsc_mode_type    mode;
  } igsc_ctrl_type;

  localparam igsc_ctrl_type CTRL_RESET = '{
    genTrigRising: 1'b0, genTrigWait: 1'b0, earlyBiasOn: 1'b0,
    contCleans: 1'b0, shutter: SHUT_ELECTRONIC, syncRising: 1'b0,
    timing: TIMING_FREE_RUN, mode: MODE_SAFE};

  // gray codes along clean, wait, finish, expose, compensate, readout
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_WAIT   = 3'h1,
    ST_FINISH = 3'h3,
    ST_EXPOSE = 3'h2,
    ST_COMP   = 3'h6,
    ST_READ   = 3'h7
  } igsc_state_type;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'h0,
    GEN_ON   = 2'h1,
    GEN_AUX  = 2'h3
  } igsc_gen_type;

  localparam logic [31:0] EXPOSURE_RESET   = 32'h0000_0000;
  localparam logic [15:0] GATE_WIDTH_RESET = 16'h0010;

  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned COMP_TIME_MS   = 6;
  localparam int unsigned COMP_CYCLES    =
    COMP_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CLEAN_CYCLES   = 400;
  localparam int unsigned READOUT_CYCLES = 2000;

endpackage

/* tb_top.sv */
// Purpose: self-checking bench of the acquisition controller.
// Assumes: shortened compensation, clean and readout counts.
// Notes:   register rows first, then frames and the awkward cases.
`timescale 1ns/100ps
module tb_top
  import igsc_pkg::*;
;
  localparam int COMP  = 20;
  localparam int RDLEN = 16;
  typedef struct {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } igsc_row_type;
  logic         clk, reset, clkEn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         extSyncPin, genTrigPin, overloadPin, cathodeBias;
  logic         alarmSound, gateStartPulse, gateStopPulse, auxPulse;
  logic         exposureActive, readoutActive, cleaning, genBusy, irq;
  logic         lastErr;
  logic [4:0]   watch;
  int           miscompares, checked, c, g;
  igsc_row_type rows [8] = '{
    '{1'h0, OFS_CTRL, 32'h0, 32'h22}, '{1'h0, OFS_EXPOSURE, 32'h0, 32'h0},
    '{1'h0, OFS_GATE_WIDTH, 32'h0, 32'h10},
    '{1'h1, OFS_EXPOSURE, 32'h5, 32'h0},
    '{1'h1, OFS_GATE_WIDTH, 32'h3, 32'h0},
    '{1'h1, OFS_INT_MASK, 32'h1F, 32'h0},
    '{1'h0, OFS_EXPOSURE, 32'h0, 32'h5},
    '{1'h0, OFS_GATE_WIDTH, 32'h0, 32'h3}};

  assign watch = {auxPulse, gateStopPulse, gateStartPulse, readoutActive,
                  exposureActive};

  igsc_controller #(.COMP_LEN(COMP), .CLEAN_LEN(8), .READOUT_LEN(RDLEN),
    .GEN_FITTED(1'h1)) igsc_controller_inst (.clk, .reset, .clkEn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .extSyncPin, .genTrigPin, .overloadPin, .cathodeBias, .alarmSound,
    .gateStartPulse, .gateStopPulse, .auxPulse, .exposureActive,
    .readoutActive, .cleaning, .genBusy, .irq);
  igsc_partner partner_inst (.clk, .extSyncPin, .genTrigPin, .overloadPin);

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    checked++;
    if (v !== e)
    begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", nm, e, v);
    end
  endtask

  task guard(input int k, input int lim);
    if (k >= lim)
    begin
      miscompares++;
      finish_test();
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (k = 0; k < 9 && pready !== 1'h1; k++)
      @(posedge clk);
    guard(k, 9);
    rd = prdata;
    lastErr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task waitOn(input int s);
    int k;
    for (k = 0; k < 4000 && watch[s] !== 1'h1; k++)
      @(posedge clk);
    guard(k, 4000);
  endtask

  // leaves c at the number of sampled cycles the watched level stayed high
  task span(input int s);
    for (c = 0; c < 9999 && watch[s] === 1'h1; c++)
      @(posedge clk);
    guard(c, 9999);
  endtask

  task irqIs(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", 32'(e), 32'(irq));
  endtask

  initial
  begin
    reset   = 1'h1;
    clkEn   = 1'h1;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("register", rows[i].e, rd);
    end
    apb(1'h0, 8'h1C, 32'h0);
    chk("pslverr", 32'h1, 32'(lastErr));
    // falling edge with electronic shutter, then rising with none
    for (int i = 0; i < 2; i++)
    begin
      apb(1'h1, OFS_CTRL, i ? 32'h14 : 32'h24);
      apb(1'h1, OFS_COMMAND, 32'h1);
      repeat (20) @(posedge clk);
      partner_inst.drive(0, 1'h1);
      if (i == 0)
      begin
        repeat (20) @(posedge clk);
        chk("wrong edge", 32'h0, 32'(exposureActive));
        partner_inst.drive(0, 1'h0);
      end
      waitOn(0);
      @(posedge clk);
      chk("bias", 32'h1, 32'(cathodeBias));
      span(0);
      chk("exposure", 32'h4, c);
      for (g = 0; g < 99 && readoutActive !== 1'h1; g++)
        @(posedge clk);
      chk("compensation", i ? 0 : COMP, g);
      span(1);
      chk("readout", RDLEN, c);
      apb(1'h0, OFS_INT_STATUS, 32'h0);
      chk("events", 32'h3, rd);
      irqIs(1'h1);
      apb(1'h1, OFS_INT_MASK, 32'h0);
      irqIs(1'h0);
      apb(1'h1, OFS_INT_MASK, 32'h1F);
      apb(1'h1, OFS_INT_STATUS, 32'h3);
      irqIs(1'h0);
      apb(1'h1, OFS_COMMAND, 32'h2);
    end
    // early bias while armed, dropped by the overload alarm
    apb(1'h1, OFS_CTRL, 32'h114);
    apb(1'h1, OFS_COMMAND, 32'h1);
    repeat (20) @(posedge clk);
    chk("early bias", 32'h1, 32'(cathodeBias));
    partner_inst.drive(2, 1'h1);
    repeat (10) @(posedge clk);
    chk("alarm", 32'h1, 32'(alarmSound));
    chk("alarm bias", 32'h0, 32'(cathodeBias));
    partner_inst.drive(2, 1'h0);
    repeat (10) @(posedge clk);
    chk("bias back", 32'h1, 32'(cathodeBias));
    apb(1'h0, OFS_INT_STATUS, 32'h0);
    chk("overload bit", 32'h4, rd & 32'h4);
    apb(1'h1, OFS_COMMAND, 32'h2);
    // safe mode runs a whole frame with the bias never on
    apb(1'h1, OFS_CTRL, 32'h116);
    apb(1'h1, OFS_COMMAND, 32'h1);
    partner_inst.drive(0, 1'h0);
    repeat (5) @(posedge clk);
    partner_inst.drive(0, 1'h1);
    c = 0;
    g = 0;
    repeat (150)
    begin
      @(posedge clk);
      c += int'(readoutActive === 1'h1);
      g += int'(cathodeBias !== 1'h0);
    end
    chk("safe bias", 32'h0, g);
    chk("safe frame", RDLEN, c);
    apb(1'h1, OFS_COMMAND, 32'h2);
    // gate mode asked with external timing, generator waits for its trigger
    apb(1'h1, OFS_CTRL, 32'h605);
    apb(1'h0, OFS_INT_STATUS, 32'h0);
    chk("reject", 32'h10, rd & 32'h10);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("timing", 32'h2, (rd >> 3) & 32'h3);
    apb(1'h1, OFS_EXPOSURE, 32'h9);
    apb(1'h0, OFS_EXPOSURE, 32'h0);
    chk("locked exposure", 32'h5, rd);
    apb(1'h1, OFS_COMMAND, 32'h1);
    g = 0;
    repeat (30)
    begin
      @(posedge clk);
      g += int'(gateStartPulse !== 1'h0);
    end
    chk("untriggered", 32'h0, g);
    partner_inst.drive(1, 1'h1);
    waitOn(2);
    for (c = 0; c < 50 && gateStopPulse !== 1'h1; c++)
    begin
      @(posedge clk);
      if (c == 1)
        chk("gate bias", 32'h1, 32'(cathodeBias));
    end
    chk("gate width", 32'h3, c);
    @(posedge clk);
    chk("aux", 32'h1, 32'(auxPulse));
    waitOn(1);
    chk("busy at readout", 32'h0, 32'(genBusy));
    apb(1'h1, OFS_COMMAND, 32'h2);
    finish_test();
  end
endmodule

bind igsc_controller igsc_asserts igsc_asserts_inst (.clk, .reset, .psel,
  .penable, .pready, .cathodeBias, .alarmSound, .gateStartPulse,
  .gateStopPulse, .auxPulse, .exposureActive, .readoutActive, .cleaning,
  .genBusy);
